// [design/cfie_defines.svh]
// Constants for the control-flow execution unit
`ifndef CFIE_DEFINES_SVH
`define CFIE_DEFINES_SVH

// Status register bit positions
`define CFIE_SR_C 3'h0
`define CFIE_SR_Z 3'h1
`define CFIE_SR_N 3'h2
`define CFIE_SR_V 3'h3
`define CFIE_SR_S 3'h4
`define CFIE_SR_H 3'h5
`define CFIE_SR_T 3'h6
`define CFIE_SR_I 3'h7

`define CFIE_STATUS_REGISTER_RESET 8'h00
`define CFIE_PC_RESET 'h0

// Execution lengths in clock cycles
`define CFIE_CNT_W 3
`define CFIE_CYC_EXT_ENTRY 3'h4
`define CFIE_CYC_ABS_ENTRY 3'h5
`define CFIE_CYC_SUB_EXIT 3'h5
`define CFIE_CYC_INT_EXIT 3'h5
`define CFIE_CYC_BR_TAKEN 3'h2
`define CFIE_CYC_SKIP_ONE 3'h2
`define CFIE_CYC_SKIP_TWO 3'h3

// Program counter advance for skips and calls
`define CFIE_ADV_SKIP_ONE 'h2
`define CFIE_ADV_SKIP_TWO 'h3
`define CFIE_ADV_TWO_WORD 'h2

`define CFIE_OFFSET_W 7

`endif

// [design/cfie_pkg.sv]
// Types shared by the control-flow execution unit
package cfie_pkg;

  typedef enum logic [4:0] {
    OP_PLAIN          = 5'h00,
    OP_EXT_IND_ENTRY  = 5'h01,
    OP_ABS_ENTRY      = 5'h02,
    OP_SUB_EXIT       = 5'h03,
    OP_INT_EXIT       = 5'h04,
    OP_CMP_SKIP_EQ    = 5'h05,
    OP_CMP_IMM        = 5'h06,
    OP_SKIP_REG_CLR   = 5'h07,
    OP_SKIP_REG_SET   = 5'h08,
    OP_SKIP_IO_CLR    = 5'h09,
    OP_SKIP_IO_SET    = 5'h0a,
    OP_BR_STAT_SET    = 5'h0b,
    OP_BR_STAT_CLR    = 5'h0c,
    OP_BR_ZERO        = 5'h0d,
    OP_BR_NONZERO     = 5'h0e,
    OP_BR_CARRY_CLR   = 5'h0f,
    OP_BR_SAME_HIGHER = 5'h10,
    OP_BR_SIGNED_GE   = 5'h11,
    OP_BR_SIGNED_LT   = 5'h12,
    OP_BR_HALF_SET    = 5'h13,
    OP_BR_TBIT_CLR    = 5'h14,
    OP_BR_OVF_SET     = 5'h15
  } cfie_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } cfie_state_t;

endpackage : cfie_pkg

// [design/cfie_stack_if.sv]
// Return-address stack port between the executor and its memory
interface cfie_stack_if #(
  parameter int WIDTH = 22,
  parameter int AW = 4
);
  logic wrEn;
  logic rdEn;
  logic [AW-1:0] addr;
  logic [WIDTH-1:0] wrData;
  logic [WIDTH-1:0] rdData;

  modport master (output wrEn, output rdEn, output addr, output wrData,
                  input rdData);
  modport mem (input wrEn, input rdEn, input addr, input wrData,
               output rdData);
endinterface : cfie_stack_if

// [design/cfie_stack_mem.sv]
// Return-address stack memory with registered read data
module cfie_stack_mem #(
  parameter int WIDTH = 22,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  cfie_stack_if.mem port
);

  logic [WIDTH-1:0] mem [2**AW];
  logic [WIDTH-1:0] rdData_reg;

  always_ff @(posedge clk_sys) begin
    if (port.wrEn) begin
      mem[port.addr] <= port.wrData;
    end
    if (port.rdEn) begin
      rdData_reg <= mem[port.addr];
    end
  end

  assign port.rdData = rdData_reg;

endmodule : cfie_stack_mem

// [design/cfie_cond.sv]
// Branch and skip condition evaluation
`include "cfie_defines.svh"

module cfie_cond (
  input wire cfie_pkg::cfie_op_t op,
  input wire logic [7:0] status_register,
  input wire logic [2:0] bitSel,
  input wire logic [7:0] regA,
  input wire logic [7:0] regB,
  input wire logic [7:0] ioData,
  output logic condMet
);
  import cfie_pkg::*;

  function automatic logic pick(input logic [7:0] v, input logic [2:0] b);
    pick = v[b];
  endfunction : pick

  logic fZ, fC, fN, fV, fH, fT;

  always_comb begin
    fZ = pick(status_register, `CFIE_SR_Z);
    fC = pick(status_register, `CFIE_SR_C);
    fN = pick(status_register, `CFIE_SR_N);
    fV = pick(status_register, `CFIE_SR_V);
    fH = pick(status_register, `CFIE_SR_H);
    fT = pick(status_register, `CFIE_SR_T);
    unique case (op)
      OP_CMP_SKIP_EQ: condMet = (regA == regB);
      OP_SKIP_REG_CLR: condMet = ~pick(regB, bitSel);
      OP_SKIP_REG_SET: condMet = pick(regB, bitSel);
      OP_SKIP_IO_CLR: condMet = ~pick(ioData, bitSel);
      OP_SKIP_IO_SET: condMet = pick(ioData, bitSel);
      OP_BR_STAT_SET: condMet = pick(status_register, bitSel);
      OP_BR_STAT_CLR: condMet = ~pick(status_register, bitSel);
      OP_BR_ZERO: condMet = fZ;
      OP_BR_NONZERO: condMet = ~fZ;
      OP_BR_CARRY_CLR, OP_BR_SAME_HIGHER: condMet = ~fC;
      OP_BR_SIGNED_GE: condMet = ~(fN ^ fV);
      OP_BR_SIGNED_LT: condMet = fN ^ fV;
      OP_BR_HALF_SET: condMet = fH;
      OP_BR_TBIT_CLR: condMet = ~fT;
      OP_BR_OVF_SET: condMet = fV;
      default: condMet = 1'b0;
    endcase
  end

endmodule : cfie_cond

// [design/cfie_exec.sv]
// Control-flow instruction executor: calls, returns, skips and branches
`include "cfie_defines.svh"

// Operation
// - Extended indirect entry: pc from high byte and Z, no flags, 4 cycles.
// - Compare-skip-equal skips next instruction when registers match, 1-3 cycles.
// - Compare immediate sets Z,N,V,C,H from register minus constant only.
// - Skip when chosen register bit is 0; pc plus 2 or 3.
// - Skip when chosen register bit is 1; pc plus 2 or 3.
// - Skip when chosen I/O bit is 0; 1, 2 or 3 cycles.
// - Skip when chosen I/O bit is 1; pc plus 2 or 3.
// - Branch to pc plus offset plus 1 when selected status bit set.
// - Branch when selected status bit clear; 1 cycle untaken, 2 taken.
// - Branch on zero flag set, or on it clear; flags untouched.
// - Carry-clear branch and same-or-higher alias branch when carry is 0.
// - Signed greater-or-equal branch when negative xor overflow is 0.
// - Signed less-than branch when negative xor overflow is 1.
// - Branch when half-carry flag is 1.
// - Branch when T flag is 0; flags unchanged.
// - Branch when overflow flag is 1; 1 cycle untaken, 2 taken.
module cfie_exec #(
  parameter int PCW = 22,
  parameter int STACK_AW = 4
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instrValid,
  input wire cfie_pkg::cfie_op_t instrOp,
  input wire logic [2:0] bitSel,
  input wire logic [`CFIE_OFFSET_W-1:0] branchOffset,
  input wire logic [7:0] immK,
  input wire logic [7:0] regA,
  input wire logic [7:0] regB,
  input wire logic [7:0] ioData,
  input wire logic [15:0] zPtr,
  input wire logic [7:0] extHigh,
  input wire logic [PCW-1:0] callTarget,
  input wire logic nextTwoWord,
  input wire logic sregLoad,
  input wire logic [7:0] sregIn,
  output logic instrReady,
  output logic [PCW-1:0] pcOut,
  output logic [7:0] statusRegOut
);
  import cfie_pkg::*;

  if (PCW < 16 || PCW > 24) begin : g_pcw_check
    $error("PCW must lie between 16 and 24");
  end
  if (STACK_AW < 1 || STACK_AW > 12) begin : g_stack_check
    $error("STACK_AW must lie between 1 and 12");
  end

  typedef struct packed {
    cfie_state_t state;
    logic [`CFIE_CNT_W-1:0] cnt;
    logic popPend;
    logic intExit;
    logic [PCW-1:0] pc;
    logic [7:0] status_register;
    logic [STACK_AW-1:0] sp;
    logic ready;
  } cfie_exec_st_t;

  cfie_exec_st_t st_reg;
  cfie_exec_st_t st_next;

  logic rstMeta_reg;
  logic rstSync_reg;
  logic condMet;

  cfie_stack_if #(.WIDTH(PCW), .AW(STACK_AW)) stackPort ();

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  cfie_cond u_cond (
    .op(instrOp),
    .status_register(st_reg.status_register),
    .bitSel(bitSel),
    .regA(regA),
    .regB(regB),
    .ioData(ioData),
    .condMet(condMet)
  );

  cfie_stack_mem #(.WIDTH(PCW), .AW(STACK_AW)) u_stack (
    .clk_sys(clk_sys),
    .port(stackPort)
  );

  // Compare-immediate flag arithmetic
  function automatic logic [7:0] cmpFlags(input logic [7:0] sr,
                                          input logic [7:0] a,
                                          input logic [7:0] k);
    logic [7:0] r;
    logic [7:0] f;
    r = a - k;
    f = sr;
    f[`CFIE_SR_H] = (~a[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~a[3]);
    f[`CFIE_SR_V] = (a[7] & ~k[7] & ~r[7]) | (~a[7] & k[7] & r[7]);
    f[`CFIE_SR_N] = r[7];
    f[`CFIE_SR_Z] = (r == 8'h00);
    f[`CFIE_SR_C] = (~a[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~a[7]);
    cmpFlags = f;
  endfunction : cmpFlags

  logic accept;
  logic isSkip;
  logic isBranch;
  logic [PCW-1:0] pcSeq;
  logic [PCW-1:0] pcRel;
  logic [PCW-1:0] pcSkip;
  logic [`CFIE_CNT_W-1:0] skipCyc;
  logic [`CFIE_CNT_W-1:0] cycles;

  always_comb begin
    accept = instrValid && st_reg.ready;
    isSkip = instrOp inside {OP_CMP_SKIP_EQ, OP_SKIP_REG_CLR,
                             OP_SKIP_REG_SET, OP_SKIP_IO_CLR,
                             OP_SKIP_IO_SET};
    isBranch = instrOp inside {OP_BR_STAT_SET, OP_BR_STAT_CLR, OP_BR_ZERO,
                               OP_BR_NONZERO, OP_BR_CARRY_CLR,
                               OP_BR_SAME_HIGHER, OP_BR_SIGNED_GE,
                               OP_BR_SIGNED_LT, OP_BR_HALF_SET,
                               OP_BR_TBIT_CLR, OP_BR_OVF_SET};
    pcSeq = st_reg.pc + PCW'(1);
    pcRel = pcSeq + {{(PCW-`CFIE_OFFSET_W){branchOffset[`CFIE_OFFSET_W-1]}},
                     branchOffset};
    pcSkip = nextTwoWord ? st_reg.pc + PCW'(`CFIE_ADV_SKIP_TWO)
                         : st_reg.pc + PCW'(`CFIE_ADV_SKIP_ONE);
    skipCyc = nextTwoWord ? `CFIE_CYC_SKIP_TWO : `CFIE_CYC_SKIP_ONE;
  end

  always_comb begin
    st_next = st_reg;
    cycles = `CFIE_CNT_W'(1);
    stackPort.wrEn = 1'b0;
    stackPort.rdEn = 1'b0;
    stackPort.addr = st_reg.sp;
    stackPort.wrData = pcSeq;
    if (sregLoad) begin
      st_next.status_register = sregIn;
    end
    unique case (st_reg.state)
      ST_IDLE: begin
        if (accept) begin
          st_next.pc = pcSeq;
          unique case (instrOp)
            OP_EXT_IND_ENTRY: begin
              st_next.pc = PCW'({extHigh, zPtr});
              stackPort.wrEn = 1'b1;
              st_next.sp = st_reg.sp + STACK_AW'(1);
              cycles = `CFIE_CYC_EXT_ENTRY;
            end
            OP_ABS_ENTRY: begin
              st_next.pc = callTarget;
              stackPort.wrEn = 1'b1;
              stackPort.wrData = st_reg.pc + PCW'(`CFIE_ADV_TWO_WORD);
              st_next.sp = st_reg.sp + STACK_AW'(1);
              cycles = `CFIE_CYC_ABS_ENTRY;
            end
            OP_SUB_EXIT, OP_INT_EXIT: begin
              stackPort.rdEn = 1'b1;
              stackPort.addr = st_reg.sp - STACK_AW'(1);
              st_next.sp = st_reg.sp - STACK_AW'(1);
              st_next.popPend = 1'b1;
              st_next.intExit = (instrOp == OP_INT_EXIT);
              cycles = (instrOp == OP_INT_EXIT) ? `CFIE_CYC_INT_EXIT
                                                : `CFIE_CYC_SUB_EXIT;
            end
            OP_CMP_IMM: begin
              st_next.status_register = cmpFlags(st_reg.status_register, regA, immK);
            end
            default: begin
              if (isSkip && condMet) begin
                st_next.pc = pcSkip;
                cycles = skipCyc;
              end else if (isBranch && condMet) begin
                st_next.pc = pcRel;
                cycles = `CFIE_CYC_BR_TAKEN;
              end
            end
          endcase
          if (cycles != `CFIE_CNT_W'(1)) begin
            st_next.state = ST_WAIT;
            st_next.cnt = cycles - `CFIE_CNT_W'(1);
            st_next.ready = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (st_reg.cnt == `CFIE_CNT_W'(1)) begin
          st_next.state = ST_IDLE;
          st_next.ready = 1'b1;
          st_next.cnt = `CFIE_CNT_W'(0);
          if (st_reg.popPend) begin
            st_next.pc = stackPort.rdData;
            st_next.popPend = 1'b0;
            st_next.intExit = 1'b0;
            if (st_reg.intExit) begin
              st_next.status_register[`CFIE_SR_I] = 1'b1;
            end
          end
        end else begin
          st_next.cnt = st_reg.cnt - `CFIE_CNT_W'(1);
        end
      end
      default: begin
        st_next.state = ST_IDLE;
        st_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      st_reg.state <= ST_IDLE;
      st_reg.cnt <= '0;
      st_reg.popPend <= 1'b0;
      st_reg.intExit <= 1'b0;
      st_reg.pc <= PCW'(`CFIE_PC_RESET);
      st_reg.status_register <= `CFIE_STATUS_REGISTER_RESET;
      st_reg.sp <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign instrReady = st_reg.ready;
  assign pcOut = st_reg.pc;
  assign statusRegOut = st_reg.status_register;

endmodule : cfie_exec

// [verif/cfie_exec_asserts.sv]
// Concurrent checks on the control-flow executor ports
`include "cfie_defines.svh"
module cfie_exec_asserts #(parameter int PCW = 22) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instrValid,
  input wire cfie_pkg::cfie_op_t instrOp,
  input wire logic [2:0] bitSel,
  input wire logic [6:0] branchOffset,
  input wire logic [7:0] immK,
  input wire logic [7:0] regA,
  input wire logic [7:0] regB,
  input wire logic [7:0] ioData,
  input wire logic [15:0] zPtr,
  input wire logic [7:0] extHigh,
  input wire logic [PCW-1:0] callTarget,
  input wire logic nextTwoWord,
  input wire logic sregLoad,
  input wire logic [7:0] sregIn,
  input wire logic instrReady,
  input wire logic [PCW-1:0] pcOut,
  input wire logic [7:0] statusRegOut
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfie_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic go = instrValid && instrReady;
  wire logic [PCW-1:0] rel = pcOut + 1'b1 + PCW'(signed'(branchOffset));
  sequence busy1; !instrReady ##1 instrReady; endsequence
  sequence busy3; !instrReady [*3] ##1 instrReady; endsequence
  sequence busy4; !instrReady [*4] ##1 instrReady; endsequence
  a_ext_entry_jump: assert property (go && instrOp == OP_EXT_IND_ENTRY |=>
    pcOut == PCW'($past({extHigh, zPtr})) ##0 busy3) else $error("ext entry");
  a_compare_skip_equal_skip_one: assert property (go && instrOp == OP_CMP_SKIP_EQ &&
    regA == regB && !nextTwoWord |=> pcOut == PCW'($past(pcOut) + 2) ##0 busy1)
    else $error("compare skip");
  a_io_skip_two: assert property (go && instrOp == OP_SKIP_IO_CLR &&
    !ioData[bitSel] && nextTwoWord |=> pcOut == PCW'($past(pcOut) + 3)
    ##0 !instrReady ##1 busy1) else $error("io skip");
  a_reg_skip_miss: assert property (go && instrOp == OP_SKIP_REG_SET &&
    !regB[bitSel] |=> instrReady && pcOut == PCW'($past(pcOut) + 1))
    else $error("reg skip");
  a_zero_branch: assert property (go && instrOp == OP_BR_ZERO &&
    statusRegOut[1] |=> pcOut == $past(rel) ##0 busy1) else $error("zero br");
  a_signed_lt_miss: assert property (go && instrOp == OP_BR_SIGNED_LT &&
    !(statusRegOut[2] ^ statusRegOut[3]) |=> instrReady &&
    pcOut == PCW'($past(pcOut) + 1)) else $error("signed lt");
  a_ovf_br_flags: assert property (go && instrOp == OP_BR_OVF_SET &&
    !statusRegOut[3] && !sregLoad |=> instrReady && $stable(statusRegOut))
    else $error("ovf branch");
  a_cmp_imm_flags: assert property (go && instrOp == OP_CMP_IMM &&
    !sregLoad |=> instrReady && statusRegOut[1] == ($past(regA) == $past(immK))
    && statusRegOut[0] == ($past(regA) < $past(immK)) &&
    statusRegOut[4] == $past(statusRegOut[4])) else $error("cmp imm");
  a_abs_entry_jump: assert property (go && instrOp == OP_ABS_ENTRY |=>
    pcOut == $past(callTarget) ##0 busy4) else $error("abs entry");
  a_int_exit_ie: assert property (go && instrOp == OP_INT_EXIT |=>
    busy4 ##0 statusRegOut[7]) else $error("int exit");
endmodule : cfie_exec_asserts

// [verif/cfie_exec_tb.sv]
// Self-checking bench for the control-flow executor
module cfie_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfie_pkg::*;
  logic clk_sys, rst_b, instrValid, nextTwoWord, sregLoad, instrReady, t;
  cfie_op_t instrOp;
  logic [2:0] bitSel, adv;
  logic [6:0] branchOffset;
  logic [7:0] immK, regA, regB, ioData, extHigh, sregIn, statusRegOut, sr, r;
  logic [15:0] zPtr;
  logic [21:0] callTarget, pcOut, pc, p0, p1;
  int n_fail, compares;
  logic [7:0] srTab [4] = '{8'h00, 8'hff, 8'h04, 8'h69};
  logic [7:0] aTab [4] = '{8'h05, 8'h00, 8'h80, 8'h7f};
  logic [7:0] kTab [4] = '{8'h05, 8'h01, 8'h01, 8'h80};
  logic [4:0] skTab [5] = '{5'h05, 5'h07, 5'h08, 5'h09, 5'h0a};
  cfie_exec u_cfie_exec (.clk_sys(clk_sys), .rst_b(rst_b),
    .instrValid(instrValid), .instrOp(instrOp), .bitSel(bitSel),
    .branchOffset(branchOffset), .immK(immK), .regA(regA), .regB(regB),
    .ioData(ioData), .zPtr(zPtr), .extHigh(extHigh),
    .callTarget(callTarget), .nextTwoWord(nextTwoWord),
    .sregLoad(sregLoad), .sregIn(sregIn), .instrReady(instrReady),
    .pcOut(pcOut), .statusRegOut(statusRegOut));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Issue one instruction, wait for completion, check pc and cycle count
  task automatic run(input logic [4:0] op, input logic [21:0] ePc,
    input logic [2:0] eCyc);
    int n;
    n = 1;
    instrOp = cfie_op_t'(op);
    instrValid = 1'b1;
    @(posedge clk_sys);
    #1;
    instrValid = 1'b0;
    while (instrReady !== 1'b1 && n < 9) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(pcOut, ePc);
    chk(n, eCyc);
    pc = ePc;
  endtask : run
  task automatic setSr(input logic [7:0] v);
    sregLoad = 1'b1;
    sregIn = v;
    @(posedge clk_sys);
    #1;
    sregLoad = 1'b0;
    chk(statusRegOut, v);
  endtask : setSr
  function automatic logic bc(logic [4:0] o, logic [7:0] s, logic [2:0] b);
    case (o)
      5'h0b: return s[b];
      5'h0c: return !s[b];
      5'h0d: return s[1];
      5'h0e: return !s[1];
      5'h0f, 5'h10: return !s[0];
      5'h11: return !(s[2] ^ s[3]);
      5'h12: return s[2] ^ s[3];
      5'h13: return s[5];
      5'h14: return !s[6];
      default: return s[3];
    endcase
  endfunction : bc
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    #200us;
    n_fail++;
    results();
  end
  initial begin
    {instrValid, nextTwoWord, sregLoad, rst_b, bitSel, branchOffset} = '0;
    {immK, regA, regB, ioData, extHigh, sregIn, zPtr, callTarget} = '0;
    instrOp = OP_PLAIN;
    n_fail = 0;
    compares = 0;
    pc = '0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    chk({instrReady, statusRegOut, pcOut}, 31'h40000000);
    repeat (3) @(posedge clk_sys);
    #1;
    for (int o = 11; o <= 21; o++) begin
      for (int j = 0; j < 4; j++) begin
        sr = srTab[j];
        setSr(sr);
        bitSel = 3'(o + j);
        branchOffset = j[0] ? 7'h7a : 7'h05;
        t = bc(5'(o), sr, bitSel);
        run(5'(o), t ? pc + 22'h1 + 22'(signed'(branchOffset)) : pc + 22'h1,
          t ? 3'h2 : 3'h1);
        chk(statusRegOut, sr);
      end
    end
    $display("test branches done");
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 4; j++) begin
        regA = 8'h3c;
        regB = j[1] ? 8'h3c : 8'h5a;
        ioData = ~regB;
        bitSel = 3'(j * 3);
        nextTwoWord = j[0];
        case (skTab[i])
          5'h05: t = regA == regB;
          5'h07: t = !regB[bitSel];
          5'h08: t = regB[bitSel];
          5'h09: t = !ioData[bitSel];
          default: t = ioData[bitSel];
        endcase
        adv = t ? (nextTwoWord ? 3'h3 : 3'h2) : 3'h1;
        run(skTab[i], pc + 22'(adv), adv);
        chk(statusRegOut, sr);
      end
    end
    $display("test skips done");
    setSr(8'h50);
    for (int j = 0; j < 4; j++) begin
      regA = aTab[j];
      immK = kTab[j];
      r = regA - immK;
      run(5'h06, pc + 22'h1, 3'h1);
      chk(statusRegOut, {2'b01, regA[3:0] < immK[3:0], 1'b1,
        regA[7] != immK[7] && r[7] != regA[7], r[7], r == 8'h00,
        regA < immK});
    end
    // A side load in the same cycle must lose to the compare's own flags
    sr = statusRegOut;
    sregLoad = 1'b1;
    sregIn = 8'h8f;
    run(5'h06, pc + 22'h1, 3'h1);
    sregLoad = 1'b0;
    chk(statusRegOut, sr);
    @(posedge clk_sys);
    #1;
    $display("test compare done");
    setSr(8'h00);
    extHigh = 8'h3f;
    zPtr = 16'h1234;
    p0 = pc;
    run(5'h01, 22'h3f1234, 3'h4);
    chk(statusRegOut, 8'h00);
    p1 = pc;
    callTarget = 22'h2aaaa;
    run(5'h02, callTarget, 3'h5);
    run(5'h03, p1 + 22'h2, 3'h5);
    run(5'h03, p0 + 22'h1, 3'h5);
    p1 = pc;
    callTarget = 22'h15555;
    run(5'h02, callTarget, 3'h5);
    run(5'h04, p1 + 22'h2, 3'h5);
    chk(statusRegOut, 8'h80);
    $display("test calls done");
    results();
  end
endmodule : cfie_exec_tb
bind cfie_exec cfie_exec_asserts #(.PCW(PCW)) u_cfie_exec_asserts (
  .clk_sys(clk_sys), .rst_b(rst_b), .instrValid(instrValid),
  .instrOp(instrOp), .bitSel(bitSel), .branchOffset(branchOffset),
  .immK(immK), .regA(regA), .regB(regB), .ioData(ioData), .zPtr(zPtr),
  .extHigh(extHigh), .callTarget(callTarget), .nextTwoWord(nextTwoWord),
  .sregLoad(sregLoad), .sregIn(sregIn), .instrReady(instrReady),
  .pcOut(pcOut), .statusRegOut(statusRegOut));
